/* verilog/hdio_pkg.sv */
package hdio_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] PATTERN_OFF = 8'h04;
  localparam logic [7:0] DELAY_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h10;
  localparam logic [7:0] IRQ_ENABLE_OFF = 8'h14;
  localparam logic [7:0] IRQ_CLEAR_OFF = 8'h18;
  localparam logic [7:0] COMMAND_OFF = 8'h1c;
  // Control field positions
  localparam int CTRL_WIDTH3_BIT = 0;
  localparam int CTRL_LINE4_BUSY_BIT = 1;
  localparam int CTRL_POL_HIGH_BIT = 2;
  localparam int CTRL_AUTOCLR_BIT = 3;
  localparam int CTRL_ILOCK_EN_BIT = 4;
  localparam int CTRL_EDGE_LSB = 5;
  localparam int CTRL_LINE4_SPECIAL_BIT = 7;
  localparam int CTRL_BUSY_BIT = 8;
  // Command bits (write one)
  localparam int CMD_OUT_ON_BIT = 0;
  localparam int CMD_OUT_OFF_BIT = 1;
  localparam int CMD_CLEAR_BIT = 2;
  localparam int CMD_EOT_BIT = 3;
  // Interrupt event positions
  localparam int EV_START = 0;
  localparam int EV_TRIP = 1;
  localparam int EV_AUTOCLR = 2;
  localparam int EV_REJECT = 3;
  localparam int EV_WIDTH = 4;
  // Reset values
  localparam logic [8:0] CTRL_RESET = 9'h004;
  localparam logic [3:0] PATTERN_RESET = 4'h0;
  localparam logic [15:0] DELAY_RESET = 16'h0010;
  // Timing: end-of-test pulse and auto-clear tick
  localparam int CLK_HZ = 20_000_000;
  localparam int EOT_PULSE_NS = 10_000;
  localparam int EOT_CYCLES = (EOT_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES = TICK_US * (CLK_HZ / 1_000_000);
  // Start edge selection
  typedef enum logic [1:0] {
    HDIO_EDGE_FALL = 2'b00,
    HDIO_EDGE_RISE = 2'b01,
    HDIO_EDGE_BOTH = 2'b10
  } hdio_edge_t;
endpackage

/* verilog/hdio_edge_detect.sv */
`timescale 1ns/1ns
module hdio_edge_detect (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic sync1;
  logic sync2;
  logic [1:0] warm;

  // Two-stage synchroniser, then one registered copy for edges
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      level <= 1'b0;
      warm <= 2'b00;
    end
    else
    begin
      sync1 <= pin;
      sync2 <= sync1;
      level <= sync2;
      if (warm != 2'b11)
        warm <= warm + 2'b01;
    end
  end

  // Edges only once the pipe holds real pin values: no false edge after reset
  wire primed = (warm == 2'b11);
  assign rise = primed & sync2 & ~level;
  assign fall = primed & ~sync2 & level;
endmodule

/* verilog/hdio_port.sv */
`timescale 1ns/1ns
module hdio_port #(
  parameter bit HAS_HANDLER = 1'b1,
  parameter int DELAY_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic start_of_test_input,
  input wire logic interlock_line,
  input wire logic test_busy,
  output logic [3:0] bin_lines,
  output logic main_output_on,
  output logic handler_arm_event,
  output logic irq
);
  // Registers
  logic [8:0] ctrl;
  logic [3:0] pattern;
  logic [DELAY_W-1:0] delay;
  logic [hdio_pkg::EV_WIDTH-1:0] irq_status;
  logic [hdio_pkg::EV_WIDTH-1:0] irq_enable;
  logic out_on;
  logic [15:0] eot_cnt;
  logic [15:0] tick_cnt;
  logic [DELAY_W-1:0] clr_cnt;
  logic clr_run;
  logic wr_pend;
  logic [7:0] wr_addr;

  // Synchronised inputs
  logic sot_level;
  logic sot_rise;
  logic sot_fall;
  logic lock_high;

  hdio_edge_detect u_sot (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(start_of_test_input),
    .level(sot_level),
    .rise(sot_rise),
    .fall(sot_fall)
  );

  hdio_edge_detect u_lock (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(interlock_line),
    .level(lock_high),
    .rise(),
    .fall()
  );

  // Field decode
  wire width3 = ctrl[hdio_pkg::CTRL_WIDTH3_BIT];
  wire line4_busy = ctrl[hdio_pkg::CTRL_LINE4_BUSY_BIT];
  wire pol_high = ctrl[hdio_pkg::CTRL_POL_HIGH_BIT];
  wire autoclr_en = ctrl[hdio_pkg::CTRL_AUTOCLR_BIT];
  wire ilock_en = ctrl[hdio_pkg::CTRL_ILOCK_EN_BIT];
  wire [1:0] edge_sel = ctrl[hdio_pkg::CTRL_EDGE_LSB +: 2];
  wire line4_special = ctrl[hdio_pkg::CTRL_LINE4_SPECIAL_BIT];

  // Bus decode
  wire addr_phase = hsel & hready & htrans[1];
  wire bus_wr = wr_pend;
  wire wr_ctrl = bus_wr & (wr_addr == hdio_pkg::CTRL_OFF);
  wire wr_pat = bus_wr & (wr_addr == hdio_pkg::PATTERN_OFF);
  wire wr_delay = bus_wr & (wr_addr == hdio_pkg::DELAY_OFF);
  wire wr_ien = bus_wr & (wr_addr == hdio_pkg::IRQ_ENABLE_OFF);
  wire wr_iclr = bus_wr & (wr_addr == hdio_pkg::IRQ_CLEAR_OFF);
  wire wr_cmd = bus_wr & (wr_addr == hdio_pkg::COMMAND_OFF);
  wire cmd_on = wr_cmd & hwdata[hdio_pkg::CMD_OUT_ON_BIT];
  wire cmd_off = wr_cmd & hwdata[hdio_pkg::CMD_OUT_OFF_BIT];
  wire cmd_clear = wr_cmd & hwdata[hdio_pkg::CMD_CLEAR_BIT];
  wire cmd_eot = wr_cmd & hwdata[hdio_pkg::CMD_EOT_BIT];

  // Pattern limit by width
  wire pat_ok = !width3 || (hwdata[3:0] <= 4'h7);
  wire pat_load = wr_pat & pat_ok;
  wire pat_reject = wr_pat & ~pat_ok;

  // Start events by selected edge
  wire start_ev = (edge_sel == hdio_pkg::HDIO_EDGE_FALL) ? sot_fall :
                  (edge_sel == hdio_pkg::HDIO_EDGE_RISE) ? sot_rise :
                  (edge_sel == hdio_pkg::HDIO_EDGE_BOTH) ? (sot_rise | sot_fall) :
                  1'b0;

  // Interlock gating
  wire trip = ilock_en & lock_high & out_on;
  wire on_ok = ~(ilock_en & lock_high);
  wire on_reject = cmd_on & ~on_ok;
  wire tick = (tick_cnt == 16'(hdio_pkg::TICK_CYCLES - 1));
  wire clr_done = clr_run & tick & (clr_cnt == '0);
  wire [hdio_pkg::EV_WIDTH-1:0] events = {on_reject | pat_reject, clr_done, trip, start_ev};

  // Fourth-line selection
  wire eot_act = (eot_cnt != 16'h0000);
  wire special_act = line4_busy ? test_busy : eot_act;
  wire line4_pat = pattern[3] & ~width3;
  wire line4 = line4_special ? (special_act ~^ pol_high) : line4_pat;
  wire [3:0] lines_raw = {line4, pattern[2:0]};
  wire [3:0] next_bin = (HAS_HANDLER ? lines_raw : 4'h0);

  // AHB data phase tracking
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= addr_phase & hwrite;
      if (addr_phase)
        wr_addr <= haddr[7:0];
    end
  end

  // Read data, registered at the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_phase & ~hwrite)
    begin
      unique case (haddr[7:0])
        hdio_pkg::CTRL_OFF: hrdata <= {23'h0, ctrl};
        hdio_pkg::PATTERN_OFF: hrdata <= {28'h0, pattern};
        hdio_pkg::DELAY_OFF: hrdata <= 32'(delay);
        hdio_pkg::STATUS_OFF: hrdata <= {26'h0, clr_run, eot_act, out_on, lock_high, sot_level, 1'b0};
        hdio_pkg::IRQ_STATUS_OFF: hrdata <= {28'h0, irq_status};
        hdio_pkg::IRQ_ENABLE_OFF: hrdata <= {28'h0, irq_enable};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= hdio_pkg::CTRL_RESET;
      delay <= DELAY_W'(hdio_pkg::DELAY_RESET);
      irq_enable <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= hwdata[8:0];
      if (wr_delay)
        delay <= hwdata[DELAY_W-1:0];
      if (wr_ien)
        irq_enable <= hwdata[hdio_pkg::EV_WIDTH-1:0];
    end
  end

  // Pattern holds until write, clear or auto-clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pattern <= hdio_pkg::PATTERN_RESET;
    else if (pat_load)
      pattern <= hwdata[3:0];
    else if (cmd_clear | clr_done)
      pattern <= hdio_pkg::PATTERN_RESET;
  end

  // Auto-clear timer in 100 us ticks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt <= 16'h0000;
      clr_cnt <= '0;
      clr_run <= 1'b0;
    end
    else
    begin
      tick_cnt <= (tick | pat_load) ? 16'h0000 : tick_cnt + 16'h0001;
      if (pat_load)
      begin
        clr_run <= autoclr_en;
        clr_cnt <= delay;
      end
      else if (clr_done | ~autoclr_en | cmd_clear)
        clr_run <= 1'b0;
      else if (clr_run & tick)
        clr_cnt <= clr_cnt - DELAY_W'(1);
    end
  end

  // End-of-test pulse on command
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      eot_cnt <= 16'h0000;
    else if (cmd_eot)
      eot_cnt <= 16'(hdio_pkg::EOT_CYCLES);
    else if (eot_act)
      eot_cnt <= eot_cnt - 16'h0001;
  end

  // Main output state with interlock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      out_on <= 1'b0;
    else if (trip | cmd_off)
      out_on <= 1'b0;
    else if (cmd_on & on_ok)
      out_on <= 1'b1;
  end

  // Outputs and sticky interrupts, set wins over clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bin_lines <= 4'h0;
      main_output_on <= 1'b0;
      handler_arm_event <= 1'b0;
      irq_status <= '0;
      irq <= 1'b0;
    end
    else
    begin
      bin_lines <= next_bin;
      main_output_on <= out_on & ~trip;
      handler_arm_event <= start_ev;
      irq_status <= (irq_status & ~(wr_iclr ? hwdata[hdio_pkg::EV_WIDTH-1:0] : '0)) | events;
      irq <= |(irq_status & irq_enable);
    end
  end

  // Interlock trip drops the output within two cycles
  AST_TRIP_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    (ilock_en & lock_high) |-> ##[1:2] !main_output_on) else $error("output on under interlock");
  AST_ON_REFUSED: assert property (@(posedge hclk) disable iff (!hresetn)
    (cmd_on & ilock_en & lock_high & !out_on) |=> !out_on) else $error("on not refused");
  AST_NO_AUTO_RESTORE: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(out_on)) |-> $past(cmd_on)) else $error("output on without request");
  AST_WIDTH3: assert property (@(posedge hclk) disable iff (!hresetn)
    (width3 & $changed(pattern)) |-> (pattern <= 4'h7)) else $error("pattern above 7");
  AST_PAT_OUT: assert property (@(posedge hclk) disable iff (!hresetn)
    (pat_load & !line4_special & HAS_HANDLER) |=> ##1 (bin_lines == $past(hwdata[3:0], 2)))
    else $error("bin lines wrong");
  AST_ONE_START: assert property (@(posedge hclk) disable iff (!hresetn)
    start_ev |=> !start_ev) else $error("double start");
  AST_ARM_FALL: assert property (@(posedge hclk) disable iff (!hresetn)
    (sot_fall & edge_sel == hdio_pkg::HDIO_EDGE_FALL) |=> handler_arm_event)
    else $error("fall edge missed");
  AST_ARM_BOTH: assert property (@(posedge hclk) disable iff (!hresetn)
    ((sot_rise | sot_fall) & edge_sel == hdio_pkg::HDIO_EDGE_BOTH) |=> handler_arm_event)
    else $error("edge missed");
  AST_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (!pat_load & !cmd_clear & !clr_done) |=> $stable(pattern)) else $error("pattern drift");
  // Line four, variant, end-of-test and auto-clear checks
  AST_LINE4_FREE: assert property (@(posedge hclk) disable iff (!hresetn)
    (width3 & !line4_special) |=> !bin_lines[3]) else $error("line four not free");
  AST_NO_LINES: assert property (@(posedge hclk) disable iff (!hresetn)
    (HAS_HANDLER == 1'b0) |-> (bin_lines == 4'h0)) else $error("bin lines driven");
  AST_EOT_START: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_eot |=> eot_act) else $error("end-of-test pulse missing");
  AST_BUSY_LINE: assert property (@(posedge hclk) disable iff (!hresetn)
    (line4_special & line4_busy & HAS_HANDLER) |=>
    (bin_lines[3] == ($past(test_busy) ~^ $past(pol_high)))) else $error("busy line wrong");
  AST_CLR_DONE: assert property (@(posedge hclk) disable iff (!hresetn)
    clr_done |=> ((pattern == hdio_pkg::PATTERN_RESET) || $past(pat_load)))
    else $error("auto-clear missed");
endmodule

/* verif/hdio_handler_model.sv */
`timescale 1ns/1ns
module hdio_handler_model (
  input wire logic hclk,
  output logic start_line,
  output logic lid_line
);
  // Start pin idles high, lid closed holds the line low
  initial
  begin
    start_line = 1'b1;
    lid_line = 1'b0;
  end
  // Clean start step, held well past the input sync delay
  task automatic step_start(input logic level);
    @(posedge hclk);
    start_line <= level;
    repeat (12) @(posedge hclk);
  endtask
  // Lid switch step, then wait out the settling time
  task automatic set_lid(input logic open);
    @(posedge hclk);
    lid_line <= open;
    repeat (2000) @(posedge hclk);
  endtask
endmodule

/* verif/hdio_port_bench.sv */
`timescale 1ns/1ns
module hdio_port_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic test_busy = 1'b0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [3:0] bin;
  logic [3:0] bin2;
  logic hreadyout, hresp, start_line, lid_line, main_on, main_on2, arm, irq;
  int errors = 0;
  int comparisons = 0;
  int events = 0;
  int n;

  // Clock and devices: full port plus the variant without bin lines
  always #25 hclk = ~hclk;
  hdio_handler_model handler (.hclk, .start_line, .lid_line);
  hdio_port DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .start_of_test_input(start_line),
    .interlock_line(lid_line), .test_busy, .bin_lines(bin), .main_output_on(main_on),
    .handler_arm_event(arm), .irq);
  hdio_port #(.HAS_HANDLER(1'b0)) DUT2 (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata(), .hreadyout(), .hresp(),
    .start_of_test_input(start_line), .interlock_line(lid_line), .test_busy,
    .bin_lines(bin2), .main_output_on(main_on2), .handler_arm_event(), .irq());

  // Count start events
  always @(posedge hclk)
    if (arm === 1'b1)
      events++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One single AHB-Lite transfer, waiting on hready in each phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (60000) @(posedge hclk);
    errors++;
    $display("BAD t=%0t watchdog expired", $time);
    finish_test;
  end

  // Test sequence
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    chk(main_on, 1'b0);
    rdc(hdio_pkg::CTRL_OFF, {23'h0, hdio_pkg::CTRL_RESET});
    rdc(hdio_pkg::DELAY_OFF, {16'h0, hdio_pkg::DELAY_RESET});
    wr(8'h40, 32'hffff_ffff);
    rdc(8'h40, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      wr(hdio_pkg::PATTERN_OFF, i);
      repeat (3) @(posedge hclk);
      chk(bin, i);
      chk(bin2, 4'h0);
    end
    // Three-bit width refuses large values, raising, masking, clearing irq
    wr(hdio_pkg::IRQ_ENABLE_OFF, 32'h8);
    wr(hdio_pkg::CTRL_OFF, 32'h5);
    wr(hdio_pkg::PATTERN_OFF, 32'h7);
    wr(hdio_pkg::PATTERN_OFF, 32'h9);
    repeat (3) @(posedge hclk);
    chk(bin, 4'h7);
    rdc(hdio_pkg::IRQ_STATUS_OFF, 32'h8);
    chk(irq, 1'b1);
    wr(hdio_pkg::IRQ_CLEAR_OFF, 32'h8);
    wr(hdio_pkg::IRQ_ENABLE_OFF, 32'h0);
    wr(hdio_pkg::PATTERN_OFF, 32'hc);
    repeat (3) @(posedge hclk);
    chk(irq, 1'b0);
    rdc(hdio_pkg::IRQ_STATUS_OFF, 32'h8);
    wr(hdio_pkg::IRQ_CLEAR_OFF, 32'h8);
    // Line four as busy, both polarities
    for (int k = 0; k < 4; k++)
    begin
      test_busy <= k[0];
      wr(hdio_pkg::CTRL_OFF, k[1] ? 32'h82 : 32'h86);
      repeat (4) @(posedge hclk);
      chk(bin[3], k[0] ^ k[1]);
    end
    // Line four as end-of-test pulse
    wr(hdio_pkg::CTRL_OFF, 32'h84);
    repeat (3) @(posedge hclk);
    chk(bin[3], 1'b0);
    wr(hdio_pkg::COMMAND_OFF, 32'h8);
    repeat (hdio_pkg::EOT_CYCLES - 16) @(posedge hclk);
    chk(bin[3], 1'b1);
    repeat (24) @(posedge hclk);
    chk(bin[3], 1'b0);
    // Auto-clear after a short delay, then the clear command
    wr(hdio_pkg::CTRL_OFF, 32'hc);
    wr(hdio_pkg::DELAY_OFF, 32'h1);
    wr(hdio_pkg::IRQ_ENABLE_OFF, 32'h4);
    wr(hdio_pkg::PATTERN_OFF, 32'ha);
    repeat (3) @(posedge hclk);
    chk(bin, 4'ha);
    for (n = 0; n < 12000 && bin !== 4'h0; n++) @(posedge hclk);
    chk(bin, 4'h0);
    chk(n >= hdio_pkg::TICK_CYCLES, 1'b1);
    chk(irq, 1'b1);
    wr(hdio_pkg::IRQ_ENABLE_OFF, 32'h0);
    wr(hdio_pkg::CTRL_OFF, 32'h4);
    wr(hdio_pkg::PATTERN_OFF, 32'h3);
    wr(hdio_pkg::COMMAND_OFF, 32'h4);
    repeat (3) @(posedge hclk);
    chk(bin, 4'h0);
    wr(hdio_pkg::IRQ_CLEAR_OFF, 32'hf);
    // Start events for every edge selection
    for (int m = 0; m < 3; m++)
    begin
      wr(hdio_pkg::CTRL_OFF, 32'h4 | (m << 5));
      events = 0;
      handler.step_start(1'b0);
      handler.step_start(1'b1);
      chk(events, (m == 2) ? 2 : 1);
    end
    rdc(hdio_pkg::IRQ_STATUS_OFF, 32'h1);
    wr(hdio_pkg::IRQ_CLEAR_OFF, 32'hf);
    // Interlock trip, refused turn-on, fresh request after closing
    wr(hdio_pkg::CTRL_OFF, 32'h14);
    wr(hdio_pkg::COMMAND_OFF, 32'h1);
    repeat (3) @(posedge hclk);
    chk(main_on, 1'b1);
    handler.set_lid(1'b1);
    chk(main_on, 1'b0);
    chk(main_on2, 1'b0);
    wr(hdio_pkg::COMMAND_OFF, 32'h1);
    repeat (3) @(posedge hclk);
    chk(main_on, 1'b0);
    rdc(hdio_pkg::STATUS_OFF, 32'h6);
    rdc(hdio_pkg::IRQ_STATUS_OFF, 32'ha);
    handler.set_lid(1'b0);
    chk(main_on, 1'b0);
    wr(hdio_pkg::COMMAND_OFF, 32'h1);
    repeat (3) @(posedge hclk);
    chk(main_on, 1'b1);
    chk(main_on2, 1'b1);
    rdc(hdio_pkg::STATUS_OFF, 32'ha);
    finish_test;
  end
endmodule
